// File: core/isr_pkg.sv
package isr_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  // Register indices on the plain port
  localparam logic [3:0] OFF_MARKER   = 4'h0;
  localparam logic [3:0] OFF_HSTART   = 4'h1;
  localparam logic [3:0] OFF_VSTART   = 4'h2;
  localparam logic [3:0] OFF_CORE     = 4'h3;
  localparam logic [3:0] OFF_AMP      = 4'h4;
  localparam logic [3:0] OFF_COARSE   = 4'h5;
  localparam logic [3:0] OFF_FINE     = 4'h6;
  localparam logic [3:0] OFF_CALLVL   = 4'h7;
  localparam logic [3:0] OFF_CONV     = 4'h8;
  localparam logic [3:0] OFF_NPIX     = 4'h9;
  localparam logic [3:0] OFF_NLINES   = 4'hA;
  localparam logic [3:0] OFF_STATUS   = 4'hB;
  // Reset values
  localparam logic [7:0]  RST_FINE    = 8'h80;
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [15:0] RST_WORD    = 16'h0000;
  // Amplifier control fields
  localparam int AMP_UNITY  = 4;
  localparam int AMP_ONEOUT = 5;
  localparam int AMP_STBY   = 6;
  localparam int AMP_DLY_LO = 7;
  // Converter control fields
  localparam int CNV_STBY1  = 0;
  localparam int CNV_STBY2  = 1;
  localparam int CNV_ONE    = 2;
  localparam int CNV_SWITCH = 3;
  localparam int CNV_EXTCLK = 4;
  localparam int CNV_TRI    = 5;
  localparam int CNV_DLY_LO = 6;
  localparam int CNV_GAMMA  = 9;
  localparam int CNV_INVERT = 10;
  // Window and timing figures
  localparam logic [7:0]  H_START_MAX   = 8'd98;
  localparam logic [7:0]  V_START_MAX   = 8'd137;
  localparam logic [3:0]  DLY_CODE_BIAS = 4'd3;
  localparam int          DLY_TAPS      = 13;
  localparam int          ROW_BLANK_CYC = 142;
  localparam logic [7:0]  ROW_BLANK_LAST = 8'(ROW_BLANK_CYC - 1);

  typedef struct packed {
    logic       oddForce;
    logic       evenForce;
    logic [2:0] hSub;
    logic [2:0] vSub;
    logic [7:0] hStart;
    logic [7:0] vStart;
    logic [3:0] gainCode;
    logic       ampUnity;
    logic       path2Standby;
    logic       ampStandby;
    logic [1:0] ampClkDly;
    logic       ampClkInv;
    logic [7:0] coarse;
    logic [7:0] fine;
    logic [7:0] calLevel;
    logic       adc1Standby;
    logic       adc2Standby;
    logic [1:0] adcClkDly;
    logic       adcClkInv;
    logic       adcExtClkSel;
  } isr_ana_ctl_t;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_HOLD, SEQ_BLANK, SEQ_READ}
    isr_seq_t;
endpackage : isr_pkg

// File: core/isr_readout.sv
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Three-stage input synchroniser, change accepted when stages two and three agree
module isr_sync (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic pinIn,
  output logic      level
);
  logic [2:0] stage;

  // Stage 0 feeds stage 1 only
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stage <= 3'h0;
      level <= 1'b0;
    end else if (ce) begin
      stage <= {stage[1:0], pinIn};
      if (stage[1] == stage[2]) level <= stage[2];
    end
  end
endmodule : isr_sync

module isr_readout (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire logic                 ce,
  input  wire logic [3:0]           regAddr,
  input  wire logic [15:0]          regWdata,
  input  wire logic                 regWr,
  input  wire logic                 regRd,
  output logic [15:0]               regRdata,
  input  wire logic                 rowClock,
  input  wire logic                 frameStart,
  input  wire logic                 adcClkExt,
  input  wire logic [9:0]           adc1Result,
  input  wire logic [9:0]           adc2Result,
  output logic                      pixelValid,
  output logic                      endOfLine,
  output logic                      endOfFrame,
  output logic [9:0]                adcDataOut,
  output logic                      adcDataOe,
  output logic                      pixelClk,
  output isr_pkg::isr_ana_ctl_t     anaCtl
);
  logic [7:0]  markerDelay, hStart, vStart, coreCtl;
  logic [7:0]  coarse, fine, calLevel;
  logic [15:0] ampCtl, convCtl;
  logic [11:0] nrofPixels, nrofLines;
  logic        rowLvl, frameLvl, extLvl, rowLvlD, extLvlD;
  isr_pkg::isr_seq_t seqState;
  logic [7:0]  blankCnt;
  logic [11:0] pixCnt, lineCnt;
  logic        readHalf, frameArmed;
  logic        rawPv, rawEol, rawEof, eofPend, pvPrev;
  localparam int DLY_TAPS_W = isr_pkg::DLY_TAPS;
  logic [DLY_TAPS_W-1:0] pvPipe, eolPipe, eofPipe;
  logic [3:0]  pvCode, mkCode;
  logic [9:0]  muxWord, muxHold, shaped;

  // Pin inputs cross through the three-stage filter
  isr_sync uRow (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
                 .pinIn(rowClock), .level(rowLvl));
  isr_sync uFrm (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
                 .pinIn(frameStart), .level(frameLvl));
  isr_sync uExt (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
                 .pinIn(adcClkExt), .level(extLvl));

  // Register writes; window starts clamp to the last legal position
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      markerDelay <= isr_pkg::RST_BYTE;
      hStart      <= isr_pkg::RST_BYTE;
      vStart      <= isr_pkg::RST_BYTE;
      coreCtl     <= isr_pkg::RST_BYTE;
      ampCtl      <= isr_pkg::RST_WORD;
      coarse      <= isr_pkg::RST_BYTE;
      fine        <= isr_pkg::RST_FINE;
      calLevel    <= isr_pkg::RST_BYTE;
      convCtl     <= isr_pkg::RST_WORD;
      nrofPixels  <= 12'h000;
      nrofLines   <= 12'h000;
    end else if (ce && regWr) begin
      case (regAddr)
        isr_pkg::OFF_MARKER: markerDelay <= regWdata[7:0];
        isr_pkg::OFF_HSTART: hStart <= (regWdata[7:0] > isr_pkg::H_START_MAX)
                               ? isr_pkg::H_START_MAX : regWdata[7:0];
        isr_pkg::OFF_VSTART: vStart <= (regWdata[7:0] > isr_pkg::V_START_MAX)
                               ? isr_pkg::V_START_MAX : regWdata[7:0];
        isr_pkg::OFF_CORE:   coreCtl  <= regWdata[7:0];
        isr_pkg::OFF_AMP:    ampCtl   <= regWdata;
        isr_pkg::OFF_COARSE: coarse   <= regWdata[7:0];
        isr_pkg::OFF_FINE:   fine     <= regWdata[7:0];
        isr_pkg::OFF_CALLVL: calLevel <= regWdata[7:0];
        isr_pkg::OFF_CONV:   convCtl  <= regWdata;
        isr_pkg::OFF_NPIX:   nrofPixels <= regWdata[11:0];
        isr_pkg::OFF_NLINES: nrofLines  <= regWdata[11:0];
        default: ;
      endcase
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      regRdata <= 16'h0000;
    end else if (ce) begin
      regRdata <= 16'h0000;
      if (regRd) begin
        case (regAddr)
          isr_pkg::OFF_MARKER: regRdata <= {8'h00, markerDelay};
          isr_pkg::OFF_HSTART: regRdata <= {8'h00, hStart};
          isr_pkg::OFF_VSTART: regRdata <= {8'h00, vStart};
          isr_pkg::OFF_CORE:   regRdata <= {8'h00, coreCtl};
          isr_pkg::OFF_AMP:    regRdata <= ampCtl;
          isr_pkg::OFF_COARSE: regRdata <= {8'h00, coarse};
          isr_pkg::OFF_FINE:   regRdata <= {8'h00, fine};
          isr_pkg::OFF_CALLVL: regRdata <= {8'h00, calLevel};
          isr_pkg::OFF_CONV:   regRdata <= convCtl;
          isr_pkg::OFF_NPIX:   regRdata <= {4'h0, nrofPixels};
          isr_pkg::OFF_NLINES: regRdata <= {4'h0, nrofLines};
          isr_pkg::OFF_STATUS: regRdata <= {2'(seqState), rawPv, frameArmed,
                                            lineCnt};
          default:             regRdata <= 16'h0000;
        endcase
      end
    end
  end

  // Analog control bundle, registered so every output leaves a flop
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      anaCtl <= '0;
    end else if (ce) begin
      anaCtl.oddForce     <= coreCtl[0];
      anaCtl.evenForce    <= coreCtl[1];
      anaCtl.hSub         <= coreCtl[4:2];
      anaCtl.vSub         <= coreCtl[7:5];
      anaCtl.hStart       <= hStart;
      anaCtl.vStart       <= vStart;
      // Gain is parked at zero while unity feedback bypasses it
      anaCtl.gainCode     <= ampCtl[isr_pkg::AMP_UNITY] ? 4'h0
                                                        : ampCtl[3:0];
      anaCtl.ampUnity     <= ampCtl[isr_pkg::AMP_UNITY];
      anaCtl.path2Standby <= ampCtl[isr_pkg::AMP_ONEOUT]
                           | ampCtl[isr_pkg::AMP_STBY];
      anaCtl.ampStandby   <= ampCtl[isr_pkg::AMP_STBY];
      anaCtl.ampClkDly    <= ampCtl[isr_pkg::AMP_DLY_LO +: 2];
      anaCtl.ampClkInv    <= ampCtl[isr_pkg::AMP_DLY_LO + 2];
      anaCtl.coarse       <= coarse;
      anaCtl.fine         <= fine;
      anaCtl.calLevel     <= calLevel;
      anaCtl.adc1Standby  <= convCtl[isr_pkg::CNV_STBY1];
      anaCtl.adc2Standby  <= convCtl[isr_pkg::CNV_STBY2];
      anaCtl.adcClkDly    <= convCtl[isr_pkg::CNV_DLY_LO +: 2];
      anaCtl.adcClkInv    <= convCtl[isr_pkg::CNV_DLY_LO + 2];
      anaCtl.adcExtClkSel <= convCtl[isr_pkg::CNV_EXTCLK];
    end
  end

  // Edge memory for row clock and external converter clock
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rowLvlD <= 1'b0;
      extLvlD <= 1'b0;
    end else if (ce) begin
      rowLvlD <= rowLvl;
      extLvlD <= extLvl;
    end
  end

  // Row sequencer: held while row clock is high, then blanking, then readout
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      seqState <= isr_pkg::SEQ_IDLE;
      blankCnt <= 8'h00;
      pixCnt   <= 12'h000;
      readHalf <= 1'b0;
      rawPv    <= 1'b0;
    end else if (ce) begin
      case (seqState)
        isr_pkg::SEQ_IDLE: begin
          if (rowLvl) seqState <= isr_pkg::SEQ_HOLD;
        end
        isr_pkg::SEQ_HOLD: begin
          blankCnt <= 8'h00;
          if (!rowLvl) seqState <= isr_pkg::SEQ_BLANK;
        end
        isr_pkg::SEQ_BLANK: begin
          blankCnt <= blankCnt + 8'h01;
          if (rowLvl) begin
            seqState <= isr_pkg::SEQ_HOLD;
          end else if (blankCnt == isr_pkg::ROW_BLANK_LAST) begin
            seqState <= isr_pkg::SEQ_READ;
            rawPv    <= 1'b1;
            pixCnt   <= 12'h000;
            readHalf <= 1'b0;
          end
        end
        isr_pkg::SEQ_READ: begin
          // Two pixels per internal clock, which is half the system clock
          readHalf <= ~readHalf;
          if (readHalf) begin
            pixCnt <= pixCnt + 12'h001;
            if (pixCnt == nrofPixels) begin
              rawPv    <= 1'b0;
              seqState <= rowLvl ? isr_pkg::SEQ_HOLD : isr_pkg::SEQ_IDLE;
            end
          end
        end
        default: seqState <= isr_pkg::SEQ_IDLE;
      endcase
      if (frameLvl) begin
        seqState <= isr_pkg::SEQ_IDLE;
        rawPv    <= 1'b0;
      end
    end
  end

  // Line counting and the raw line and frame markers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lineCnt    <= 12'h000;
      frameArmed <= 1'b0;
      rawEol     <= 1'b0;
      rawEof     <= 1'b0;
      eofPend    <= 1'b0;
    end else if (ce) begin
      rawEol <= 1'b0;
      rawEof <= 1'b0;
      if (frameLvl) begin
        lineCnt    <= 12'h000;
        frameArmed <= 1'b1;
        eofPend    <= 1'b0;
      end else if (rowLvl && !rowLvlD) begin
        // First row clock of a frame addresses line zero
        frameArmed <= 1'b0;
        if (!frameArmed) lineCnt <= lineCnt + 12'h001;
      end
      // Marker one clock after pixel-valid falls
      if (seqState == isr_pkg::SEQ_READ && readHalf
          && pixCnt == nrofPixels && !frameLvl) begin
        eofPend <= (lineCnt == nrofLines);
      end
      // One clock after the fall, so eofPend already holds this row's verdict
      if (pvPrev && !rawPv) begin
        rawEol  <= 1'b1;
        rawEof  <= eofPend;
        eofPend <= 1'b0;
      end
    end
  end

  // Pixel-valid history feeding the marker stage
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pvPrev <= 1'b0;
    end else if (ce) begin
      pvPrev <= rawPv;
    end
  end

  // Delay lines for the user-adjustable marker alignment
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pvPipe  <= '0;
      eolPipe <= '0;
      eofPipe <= '0;
    end else if (ce) begin
      pvPipe  <= {pvPipe[DLY_TAPS_W-2:0], rawPv};
      eolPipe <= {eolPipe[DLY_TAPS_W-2:0], rawEol};
      eofPipe <= {eofPipe[DLY_TAPS_W-2:0], rawEof};
    end
  end

  assign pvCode = markerDelay[3:0];
  assign mkCode = markerDelay[7:4];

  // Tap select: codes below the bias take the undelayed marker
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pixelValid <= 1'b0;
      endOfLine  <= 1'b0;
      endOfFrame <= 1'b0;
    end else if (ce) begin
      if (pvCode < isr_pkg::DLY_CODE_BIAS) pixelValid <= rawPv;
      else pixelValid <= pvPipe[pvCode - isr_pkg::DLY_CODE_BIAS];
      if (mkCode < isr_pkg::DLY_CODE_BIAS) begin
        endOfLine  <= rawEol;
        endOfFrame <= rawEof;
      end else begin
        endOfLine  <= eolPipe[mkCode - isr_pkg::DLY_CODE_BIAS];
        endOfFrame <= eofPipe[mkCode - isr_pkg::DLY_CODE_BIAS];
      end
    end
  end

  // Internal pixel clock at half the system clock
  always_ff @(posedge sys_clk) begin
    if (!rst_n) pixelClk <= 1'b0;
    else if (ce) pixelClk <= ~pixelClk;
  end

  // Companding curve: steep in the dark, flattened in the bright
  function automatic logic [9:0] isr_gamma(input logic [9:0] x);
    logic [9:0] y;
    y = 10'h000;
    if (x < 10'd128) y = {x[7:0], 2'b00};
    else if (x < 10'd384) y = 10'd384 + (x - 10'd128);
    else y = 10'd640 + 10'((x - 10'd384) >> 1);
    return y;
  endfunction : isr_gamma

  // Converter multiplex; selection follows the switch bit in single mode, else the internal or external ADC clock
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      muxWord <= 10'h000;
      muxHold <= 10'h000;
    end else if (ce) begin
      if (convCtl[isr_pkg::CNV_ONE]) begin
        muxWord <= convCtl[isr_pkg::CNV_SWITCH] ? adc2Result
                                                : adc1Result;
      end else if (convCtl[isr_pkg::CNV_EXTCLK]) begin
        muxWord <= extLvl ? adc2Result : adc1Result;
      end else begin
        muxWord <= pixelClk ? adc2Result : adc1Result;
      end
      // Hold stage gives one system clock, or half an external ADC clock
      if (!convCtl[isr_pkg::CNV_EXTCLK] || (extLvl != extLvlD))
        muxHold <= muxWord;
    end
  end

  assign shaped = convCtl[isr_pkg::CNV_GAMMA] ? isr_gamma(
                    (convCtl[isr_pkg::CNV_SWITCH] && !convCtl[isr_pkg::CNV_ONE])
                    ? muxHold : muxWord)
                  : ((convCtl[isr_pkg::CNV_SWITCH] && !convCtl[isr_pkg::CNV_ONE])
                    ? muxHold : muxWord);

  // Output word and drive enable
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      adcDataOut <= 10'h000;
      adcDataOe  <= 1'b0;
    end else if (ce) begin
      adcDataOut <= convCtl[isr_pkg::CNV_INVERT] ? ~shaped : shaped;
      adcDataOe  <= ~convCtl[isr_pkg::CNV_TRI];
    end
  end

  // Run of enabled cycles, so history-based checks see unfrozen time
  logic [3:0]  ceRun;
  logic [12:0] pvLen;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ceRun <= 4'h0;
      pvLen <= 13'h0000;
    end else begin
      ceRun <= !ce ? 4'h0 : (ceRun == 4'hF) ? ceRun : ceRun + 4'h1;
      if (ce) pvLen <= rawPv ? pvLen + 13'h0001 : 13'h0000;
    end
  end

  AST_PV_TAP13: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ceRun == 4'hF && pvCode == 4'hF && $stable(pvCode))
      |-> pixelValid == $past(rawPv, 14))
    else $error("pixel-valid not delayed by 13 at code F");
  AST_PV_NODELAY: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ceRun == 4'hF && pvCode == 4'h2 && $stable(pvCode))
      |-> pixelValid == $past(rawPv))
    else $error("pixel-valid delayed at code 2");
  AST_EOL_TAP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ceRun == 4'hF && mkCode == 4'h4 && $stable(mkCode))
      |-> endOfLine == $past(rawEol, 3))
    else $error("end-of-line not delayed by 2 at code 4");
  AST_EOL_AFTER_PV: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ceRun == 4'hF && $rose(rawEol)) |-> $past(rawPv, 2) && !$past(rawPv))
    else $error("end-of-line not one clock after pixel-valid fall");
  AST_EOF_WITH_EOL: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rawEof |-> rawEol && lineCnt == nrofLines)
    else $error("end-of-frame outside last line end");
  AST_PV_LEN: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ce && rawPv) |-> pvLen <= {nrofPixels, 1'b0} + 13'h0001)
    else $error("pixel-valid longer than the programmed row");
  AST_PV_COUNT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ce && $fell(rawPv) && !$past(frameLvl) && ceRun == 4'hF)
      |-> $past(pvLen) == {nrofPixels, 1'b0} + 13'd1)
    else $error("row length differs from twice count plus two");
  AST_UNITY: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ce && $past(ce) && $past(ampCtl[isr_pkg::AMP_UNITY]))
      |-> anaCtl.ampUnity && anaCtl.gainCode == 4'h0)
    else $error("gain active during unity feedback");
  AST_PATH2: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ce && $past(ce) && $past(ampCtl[isr_pkg::AMP_ONEOUT]))
      |-> anaCtl.path2Standby)
    else $error("second path not idled in single-output mode");
  AST_TRISTATE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ce && $past(ce) && $past(convCtl[isr_pkg::CNV_TRI])) |-> !adcDataOe)
    else $error("outputs driven while disabled");

  COV_ROW: cover property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(rawPv) ##[1:1000] rawEol);
  COV_FRAME: cover property (@(posedge sys_clk) disable iff (!rst_n) rawEof);
  COV_DELAYED: cover property (@(posedge sys_clk) disable iff (!rst_n)
    pvCode == 4'hF && $rose(pixelValid));
endmodule : isr_readout
`default_nettype wire

// File: testbench/isr_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// Camera controller stand-in: drives frame start and row clock pulses
module isr_ctrl_model (
  input  wire logic sys_clk,
  input  wire logic frameReq,
  input  wire logic rowReq,
  output logic      frameStart,
  output logic      rowClock
);
  // Launched on rising edges only, so the pins never glitch
  initial begin
    frameStart = 1'b0;
    rowClock   = 1'b0;
    forever begin
      @(posedge sys_clk);
      if (frameReq) begin
        frameStart <= 1'b1;
        repeat (3) @(posedge sys_clk);
        frameStart <= 1'b0;
        repeat (2) @(posedge sys_clk);
      end else if (rowReq) begin
        rowClock <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rowClock <= 1'b0;
        repeat (2) @(posedge sys_clk);
      end
    end
  end
endmodule : isr_ctrl_model
`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                  sys_clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic [3:0]            regAddr = 4'h0;
  logic [15:0]           regWdata = 16'h0000;
  logic                  regWr = 1'b0;
  logic                  regRd = 1'b0;
  logic                  frameReq = 1'b0;
  logic                  rowReq = 1'b0;
  logic                  ce = 1'b1;
  logic                  clkPrev;
  logic [9:0]            wordA, wordB;
  logic [9:0]            adc1Result = 10'h155;
  logic [9:0]            adc2Result = 10'h0F0;
  logic [15:0]           regRdata;
  logic                  rowClock, frameStart, pixelValid, endOfLine;
  logic                  endOfFrame, adcDataOe, pixelClk, eofSeen;
  logic [9:0]            adcDataOut;
  isr_pkg::isr_ana_ctl_t anaCtl;
  int                    mismatches = 0;
  int                    samples_checked = 0;
  int                    width, gap, gapRef;
  // 200 MHz system clock
  always #2.5 sys_clk = ~sys_clk;
  // External converter clock held: one-clock bench
  isr_readout i_isr_readout (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .rowClock(rowClock), .frameStart(frameStart),
    .adcClkExt(1'b0), .adc1Result(adc1Result), .adc2Result(adc2Result),
    .pixelValid(pixelValid), .endOfLine(endOfLine), .endOfFrame(endOfFrame),
    .adcDataOut(adcDataOut), .adcDataOe(adcDataOe), .pixelClk(pixelClk),
    .anaCtl(anaCtl));
  isr_ctrl_model i_isr_ctrl_model (.sys_clk(sys_clk), .frameReq(frameReq),
    .rowReq(rowReq), .frameStart(frameStart), .rowClock(rowClock));
  // Compare and count
  task automatic check(input string w, input logic [15:0] s,
                       input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, s);
    end
  endtask : check
  // Parallel stand-in for the serial word upload; strobe lasts one cycle
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input string w,
                    input logic [15:0] e);
    @(posedge sys_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 check(w, regRdata, e);
  endtask : rd
  // Program converter control, let the two-stage path settle, compare
  task automatic adc(input logic [15:0] c, input string w,
                     input logic [9:0] e);
    wr(isr_pkg::OFF_CONV, c);
    repeat (4) @(posedge sys_clk);
    check(w, adcDataOut, e);
  endtask : adc
  // One row: bounded waits so a dead sequencer cannot hang the run
  task automatic run_line();
    @(posedge sys_clk) rowReq <= 1'b1;
    @(posedge sys_clk) rowReq <= 1'b0;
    for (int n = 0; n < 400 && pixelValid !== 1'b1; n++) begin
      @(posedge sys_clk);
    end
    for (width = 0; width < 400 && pixelValid === 1'b1; width++) begin
      @(posedge sys_clk);
    end
    for (gap = 0; gap < 40 && endOfLine !== 1'b1; gap++) begin
      @(posedge sys_clk);
    end
    eofSeen = endOfFrame;
  endtask : run_line
  task automatic test_regs();
    rd(isr_pkg::OFF_FINE, "fine reset", 16'h0080);
    rd(isr_pkg::OFF_COARSE, "coarse reset", 16'h0000);
    wr(isr_pkg::OFF_HSTART, 16'hFFFF);
    wr(isr_pkg::OFF_VSTART, 16'hFFFF);
    rd(isr_pkg::OFF_HSTART, "hstart clamp", 16'h0062);
    rd(isr_pkg::OFF_VSTART, "vstart clamp", 16'h0089);
    wr(4'hC, 16'h1234);
    rd(4'hC, "unmapped", 16'h0000);
    // A write while the enable is low must be ignored
    @(posedge sys_clk) ce <= 1'b0;
    wr(isr_pkg::OFF_COARSE, 16'h00AA);
    ce <= 1'b1;
    rd(isr_pkg::OFF_COARSE, "frozen write", 16'h0000);
    $display("test_regs done");
  endtask : test_regs
  task automatic test_ctl();
    wr(isr_pkg::OFF_CORE, 16'h0036);
    wr(isr_pkg::OFF_AMP, 16'h0230);
    repeat (3) @(posedge sys_clk);
    check("odd force", anaCtl.oddForce, 1'b0);
    check("even force", anaCtl.evenForce, 1'b1);
    check("h sub", anaCtl.hSub, 3'h5);
    check("v sub", anaCtl.vSub, 3'h1);
    check("unity", anaCtl.ampUnity, 1'b1);
    check("path2 idle", anaCtl.path2Standby, 1'b1);
    check("amp on", anaCtl.ampStandby, 1'b0);
    check("amp clk inv", anaCtl.ampClkInv, 1'b1);
    check("amp clk dly", anaCtl.ampClkDly, 2'h0);
    wr(isr_pkg::OFF_CONV, 16'h0012);
    repeat (3) @(posedge sys_clk);
    check("adc1 on", anaCtl.adc1Standby, 1'b0);
    check("adc2 idle", anaCtl.adc2Standby, 1'b1);
    check("ext clk", anaCtl.adcExtClkSel, 1'b1);
    $display("test_ctl done");
  endtask : test_ctl
  task automatic test_adc();
    adc(16'h000C, "single adc2", 10'h0F0);
    adc(16'h0404, "inverted", 10'h2AA);
    adc(16'h0004, "single adc1", 10'h155);
    check("oe on", adcDataOe, 1'b1);
    wr(isr_pkg::OFF_CONV, 16'h0024);
    repeat (3) @(posedge sys_clk);
    check("oe off", adcDataOe, 1'b0);
    // Dual mode alternates the two converters on the pixel clock
    wr(isr_pkg::OFF_CONV, 16'h0000);
    repeat (4) @(posedge sys_clk);
    wordA = adcDataOut;
    clkPrev = pixelClk;
    @(posedge sys_clk);
    wordB = adcDataOut;
    check("dual pair", 16'(wordA ^ wordB), 16'h01A5);
    check("pixel clock", {15'h0000, pixelClk}, {15'h0000, ~clkPrev});
    $display("test_adc done");
  endtask : test_adc
  // Two-line frame; marker codes move end-of-line against pixel-valid
  task automatic test_seq();
    wr(isr_pkg::OFF_NPIX, 16'h0002);
    wr(isr_pkg::OFF_NLINES, 16'h0001);
    @(posedge sys_clk) frameReq <= 1'b1;
    @(posedge sys_clk) frameReq <= 1'b0;
    repeat (8) @(posedge sys_clk);
    run_line();
    check("pv width", 16'(width), 16'h0006);
    check("eof early", eofSeen, 1'b0);
    gapRef = gap;
    wr(isr_pkg::OFF_MARKER, 16'h00F3);
    run_line();
    check("pv width 2", 16'(width), 16'h0006);
    check("eol shift", 16'(gap), 16'(gapRef + 12));
    check("eof last", eofSeen, 1'b1);
    $display("test_seq done");
  endtask : test_seq
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude
  // Main sequence after 16 reset cycles
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    test_regs();
    test_ctl();
    test_adc();
    test_seq();
    conclude();
  end
  // Watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    conclude();
  end
endmodule : testbench
`default_nettype wire
